// ---- hdl/status_cascade.sv ----
// Status event cascade: measurement, instrument summary and operation trees over AXI4-Lite.
// Assumes condition inputs synchronous to ref_clk_in and a single-beat AXI4-Lite master.
`timescale 1ns/1ps
`include "status_cascade_regs.svh"
module status_cascade
  import status_cascade_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] meas_cond_in,
  input  wire logic [WIDTH-1:0] minst_cond_in,
  input  wire logic [WIDTH-1:0] misum_cond_in,
  input  wire logic [WIDTH-1:0] oper_cond_in,
  input  wire logic [WIDTH-1:0] oinst_cond_in,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic                  meas_summary_out,
  output logic                  operation_summary_bit_out,
  output logic                  irq_out
);
  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic         aw_held_reg;
  logic         w_held_reg;
  logic [7:0]   aw_addr_reg;
  logic [31:0]  w_data_reg;
  logic [3:0]   w_strb_reg;
  logic         wr_fire;
  reg_wr_t      wr;
  logic [31:0]  wmask;

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr      = {aw_addr_reg, w_data_reg};
  assign wmask   = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr.addr[1:0] == 2'b00 && wr.addr <= `OFS_IRQ_MASK) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Writes with partial strobes merge into the old enable value.
  logic [31:0] wdat;
  assign wdat = wr.data & wmask;

  logic wr_meas_en;
  logic wr_minst_en;
  logic wr_misum_en;
  logic wr_oper_en;
  logic wr_oinst_en;
  logic preset;
  logic wr_irq_status;
  logic wr_irq_mask;

  always_comb
  begin
    wr_meas_en    = 1'b0;
    wr_minst_en   = 1'b0;
    wr_misum_en   = 1'b0;
    wr_oper_en    = 1'b0;
    wr_oinst_en   = 1'b0;
    preset        = 1'b0;
    wr_irq_status = 1'b0;
    wr_irq_mask   = 1'b0;
    if (wr_fire)
    begin
      if (wr.addr == `OFS_MEAS_ENABLE)
        wr_meas_en = 1'b1;
      else if (wr.addr == `OFS_MINST_ENABLE)
        wr_minst_en = 1'b1;
      else if (wr.addr == `OFS_MISUM_ENABLE)
        wr_misum_en = 1'b1;
      else if (wr.addr == `OFS_OPER_ENABLE)
        wr_oper_en = 1'b1;
      else if (wr.addr == `OFS_OINST_ENABLE)
        wr_oinst_en = 1'b1;
      else if (wr.addr == `OFS_PRESET)
        preset = 1'b1;
      else if (wr.addr == `OFS_IRQ_STATUS)
        wr_irq_status = 1'b1;
      else if (wr.addr == `OFS_IRQ_MASK)
        wr_irq_mask = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  rd_state_t   rd_state_reg;
  logic        rd_take;
  logic [7:0]  rd_addr;
  logic        clr_meas;
  logic        clr_minst;
  logic        clr_misum;
  logic        clr_oper;
  logic        clr_oinst;

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;
  assign clr_meas  = rd_take && rd_addr == `OFS_MEAS_EVENT;
  assign clr_minst = rd_take && rd_addr == `OFS_MINST_EVENT;
  assign clr_misum = rd_take && rd_addr == `OFS_MISUM_EVENT;
  assign clr_oper  = rd_take && rd_addr == `OFS_OPER_EVENT;
  assign clr_oinst = rd_take && rd_addr == `OFS_OINST_EVENT;

  // ----------------------------------------------------------------
  // Event cascade
  // ----------------------------------------------------------------
  status_word_t misum_ev, misum_en, minst_ev, minst_en, meas_ev, meas_en;
  status_word_t oinst_ev, oinst_en, oper_ev, oper_en;
  logic         misum_sum, minst_sum, meas_sum, oinst_sum, oper_sum;
  status_word_t minst_src, meas_src, oper_src;
  logic [1:0]   irq_status_reg;
  logic [1:0]   irq_mask_reg;

  always_comb
  begin
    minst_src = minst_cond_in;
    minst_src[`BIT_MINST_SUM] = minst_cond_in[`BIT_MINST_SUM] | misum_sum;
  end

  always_comb
  begin
    meas_src = meas_cond_in;
    meas_src[`BIT_MEAS_INSTR_SUM] = meas_cond_in[`BIT_MEAS_INSTR_SUM] | minst_sum;
  end

  always_comb
  begin
    oper_src = oper_cond_in;
    oper_src[`BIT_OPER_INSTR_SUM] = oper_cond_in[`BIT_OPER_INSTR_SUM] | oinst_sum;
  end

  event_stage #(.WIDTH(WIDTH)) u_misum (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .cond_in        (misum_cond_in),
    .read_clear_in  (clr_misum),
    .enable_wr_in   (wr_misum_en),
    .enable_data_in ((misum_en & ~wmask[15:0]) | wdat[15:0]),
    .preset_in      (preset),
    .event_out      (misum_ev),
    .enable_out     (misum_en),
    .summary_out    (misum_sum)
  );

  event_stage #(.WIDTH(WIDTH)) u_minst (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .cond_in        (minst_src),
    .read_clear_in  (clr_minst),
    .enable_wr_in   (wr_minst_en),
    .enable_data_in ((minst_en & ~wmask[15:0]) | wdat[15:0]),
    .preset_in      (preset),
    .event_out      (minst_ev),
    .enable_out     (minst_en),
    .summary_out    (minst_sum)
  );

  event_stage #(.WIDTH(WIDTH)) u_meas (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .cond_in        (meas_src),
    .read_clear_in  (clr_meas),
    .enable_wr_in   (wr_meas_en),
    .enable_data_in ((meas_en & ~wmask[15:0]) | wdat[15:0]),
    .preset_in      (preset),
    .event_out      (meas_ev),
    .enable_out     (meas_en),
    .summary_out    (meas_sum)
  );

  event_stage #(.WIDTH(WIDTH)) u_oinst (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .cond_in        (oinst_cond_in),
    .read_clear_in  (clr_oinst),
    .enable_wr_in   (wr_oinst_en),
    .enable_data_in ((oinst_en & ~wmask[15:0]) | wdat[15:0]),
    .preset_in      (preset),
    .event_out      (oinst_ev),
    .enable_out     (oinst_en),
    .summary_out    (oinst_sum)
  );

  event_stage #(.WIDTH(WIDTH)) u_oper (
    .ref_clk_in     (ref_clk_in),
    .srst_in        (srst_in),
    .cond_in        (oper_src),
    .read_clear_in  (clr_oper),
    .enable_wr_in   (wr_oper_en),
    .enable_data_in ((oper_en & ~wmask[15:0]) | wdat[15:0]),
    .preset_in      (preset),
    .event_out      (oper_ev),
    .enable_out     (oper_en),
    .summary_out    (oper_sum)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      meas_summary_out          <= 1'b0;
      operation_summary_bit_out <= 1'b0;
    end
    else
    begin
      meas_summary_out          <= meas_sum;
      operation_summary_bit_out <= oper_sum;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // A rising summary sets a sticky bit; setting wins over write-one-to-clear.
  logic [1:0] sum_now;
  logic [1:0] sum_prev_reg;
  logic [1:0] sum_rise;
  assign sum_now  = {oper_sum, meas_sum};
  assign sum_rise = sum_now & ~sum_prev_reg;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      sum_prev_reg   <= 2'b00;
      irq_status_reg <= 2'b00;
      irq_mask_reg   <= 2'b00;
      irq_out        <= 1'b0;
    end
    else
    begin
      sum_prev_reg   <= sum_now;
      irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? wdat[1:0] : 2'b00)) | sum_rise;
      if (wr_irq_mask)
        irq_mask_reg <= wdat[1:0];
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  status_word_t rd_word;
  logic         rd_ok;

  always_comb
  begin
    rd_word = '0;
    rd_ok   = 1'b1;
    if (rd_addr == `OFS_MEAS_EVENT)
      rd_word = meas_ev;
    else if (rd_addr == `OFS_MEAS_ENABLE)
      rd_word = meas_en;
    else if (rd_addr == `OFS_MINST_EVENT)
      rd_word = minst_ev;
    else if (rd_addr == `OFS_MINST_ENABLE)
      rd_word = minst_en;
    else if (rd_addr == `OFS_MISUM_EVENT)
      rd_word = misum_ev;
    else if (rd_addr == `OFS_MISUM_ENABLE)
      rd_word = misum_en;
    else if (rd_addr == `OFS_MISUM_COND)
      rd_word = misum_cond_in;
    else if (rd_addr == `OFS_OPER_EVENT)
      rd_word = oper_ev;
    else if (rd_addr == `OFS_OPER_ENABLE)
      rd_word = oper_en;
    else if (rd_addr == `OFS_OINST_EVENT)
      rd_word = oinst_ev;
    else if (rd_addr == `OFS_OINST_ENABLE)
      rd_word = oinst_en;
    else if (rd_addr == `OFS_PRESET)
      rd_word = '0;
    else if (rd_addr == `OFS_IRQ_STATUS)
      rd_word = {14'h0000, irq_status_reg};
    else if (rd_addr == `OFS_IRQ_MASK)
      rd_word = {14'h0000, irq_mask_reg};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      rd_state_reg  <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      case (rd_state_reg)
        RD_IDLE:
        begin
          s_axi_arready <= !rd_take;
          if (rd_take)
          begin
            s_axi_rdata   <= {16'h0000, rd_word};
            s_axi_rresp   <= rd_ok ? 2'b00 : 2'b10;
            s_axi_rvalid  <= 1'b1;
            rd_state_reg  <= RD_RESP;
          end
        end
        RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_state_reg  <= RD_IDLE;
          end
        end
        default:
          rd_state_reg <= RD_IDLE;
      endcase
    end
  end
endmodule : status_cascade

// ---- hdl/status_cascade_regs.svh ----
// Register offsets, field positions and reset values of the status event cascade.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
//
// Overview of operation
// - Enabled measurement instrument events set measurement summary bit.
// - Enable registers read/write, reset to zero.
// - Reading instrument summary event register clears it.
// - Event read returns binary-weighted sum of bits.
// - Enabled summary events set instrument event bit 1.
// - Enabled operation events set operation summary output.
// - Enabled operation instrument events set operation summary bit.
// - Operation and operation instrument reads clear them.
// - Summary condition register is read-only, shows present state.
// - Writing 2049 enables bits 11 and 0.
// - Writing 2 sets only enable bit 1.
// - Enabled measurement events set measurement summary output.
// - Status preset clears every enable register.
`ifndef STATUS_CASCADE_REGS_SVH
`define STATUS_CASCADE_REGS_SVH

`define OFS_MEAS_EVENT        8'h00
`define OFS_MEAS_ENABLE       8'h04
`define OFS_MINST_EVENT       8'h08
`define OFS_MINST_ENABLE      8'h0c
`define OFS_MISUM_EVENT       8'h10
`define OFS_MISUM_ENABLE      8'h14
`define OFS_MISUM_COND        8'h18
`define OFS_OPER_EVENT        8'h1c
`define OFS_OPER_ENABLE       8'h20
`define OFS_OINST_EVENT       8'h24
`define OFS_OINST_ENABLE      8'h28
`define OFS_PRESET            8'h2c
`define OFS_IRQ_STATUS        8'h30
`define OFS_IRQ_MASK          8'h34

`define BIT_MEAS_INSTR_SUM    13
`define BIT_OPER_INSTR_SUM    13
`define BIT_MINST_SUM         1
`define ENABLE_RESET          16'h0000
`define IRQ_BIT_MEAS_SUM      0
`define IRQ_BIT_OPER_SUM      1

`endif

// ---- hdl/status_cascade_pkg.sv ----
// Types shared by the status event cascade.
// Assumes the offsets header is included where numbers are needed.
package status_cascade_pkg;
  typedef logic [15:0] status_word_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } reg_wr_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_RESP = 2'b01
  } rd_state_t;
endpackage : status_cascade_pkg

// ---- hdl/event_stage.sv ----
// One event register stage: latches condition bits, clears on read, keeps enable.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "status_cascade_regs.svh"
module event_stage
  import status_cascade_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] cond_in,
  input  wire logic             read_clear_in,
  input  wire logic             enable_wr_in,
  input  wire logic [WIDTH-1:0] enable_data_in,
  input  wire logic             preset_in,
  output logic      [WIDTH-1:0] event_out,
  output logic      [WIDTH-1:0] enable_out,
  output logic                  summary_out
);
  // latch until read
  // New events in the clearing cycle survive, so none is lost.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      event_out <= '0;
    else if (read_clear_in)
      event_out <= cond_in;
    else
      event_out <= event_out | cond_in;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in || preset_in)
      enable_out <= WIDTH'(`ENABLE_RESET);
    else if (enable_wr_in)
      enable_out <= enable_data_in;
  end

  assign summary_out = |(event_out & enable_out);
endmodule : event_stage

// ---- tb/status_cascade_assertions.sv ----
// Concurrent checks on the ports of the status event cascade.
// Assumes binding into status_cascade, with one clock and a synchronous reset.
`timescale 1ns/1ps
module status_cascade_assertions #(
  parameter int WIDTH = 16
)(
  input wire logic             ref_clk_in,
  input wire logic             srst_in,
  input wire logic [WIDTH-1:0] misum_cond_in,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic             meas_summary_out,
  input wire logic             operation_summary_bit_out,
  input wire logic             irq_out
);
  // ----------------------------------------
  // Bus and summary checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  rd_pulse_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  rd_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  b_pulse_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  wr_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  rdata_upper_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  bad_addr_a:
    assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h34 || s_axi_araddr[1:0] != 2'b00)
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cond_live_a:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18 && $stable(misum_cond_in)
      |=> s_axi_rdata[WIDTH-1:0] == $past(misum_cond_in))
    else $error("condition read not live");
  reset_quiet_a:
    assert property ($fell(srst_in) |-> !irq_out && !meas_summary_out && !operation_summary_bit_out)
    else $error("outputs not cleared by reset");
endmodule : status_cascade_assertions

bind status_cascade status_cascade_assertions #(.WIDTH(WIDTH)) status_cascade_assertions_inst (
  .ref_clk_in, .srst_in, .misum_cond_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .meas_summary_out, .operation_summary_bit_out, .irq_out
);

// ---- tb/status_cascade_tb_top.sv ----
// Self-checking testbench of the status event cascade.
// Assumes the design and the checker are compiled first; bready and rready stay high.
`timescale 1ns/1ps
module status_cascade_tb_top;
  import status_cascade_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] cond [5];
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, v;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, msum, osum, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb = 4'hf;
  int          err_count = 0, checks = 0, seed = 23528;
  logic [7:0]  ev_ofs [5] = '{8'h00, 8'h08, 8'h10, 8'h1c, 8'h24};
  logic [7:0]  en_ofs [5] = '{8'h04, 8'h0c, 8'h14, 8'h20, 8'h28};
  logic [7:0]  bad [2] = '{8'h3c, 8'h06};

  always #2 clk = ~clk;

  status_cascade #(.WIDTH(16)) status_cascade_inst (
    .ref_clk_in(clk), .srst_in(srst), .meas_cond_in(cond[0]), .minst_cond_in(cond[1]),
    .misum_cond_in(cond[2]), .oper_cond_in(cond[3]), .oinst_cond_in(cond[4]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .meas_summary_out(msum), .operation_summary_bit_out(osum), .irq_out(irq)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Registers hold 16 bits; the upper half always reads zero.
  function automatic logic [31:0] fit(input logic [31:0] x);
    return {16'h0000, x[15:0]};
  endfunction : fit

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] r);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    x = rdata;
    r = rresp;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, resp);
    chk($sformatf("read %h", a), d, e);
  endtask : rchk

  task automatic pulse(input int i, input logic [15:0] b);
    cond[i] <= b;
    @(posedge clk);
    cond[i] <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    foreach (cond[i]) cond[i] = 16'h0000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    foreach (en_ofs[i])
    begin
      rchk(en_ofs[i], 32'h0);
      v = $random(seed);
      wr(en_ofs[i], v, resp);
      chk("bresp", 32'(resp), 32'h0);
      rchk(en_ofs[i], fit(v));
    end
    wr(8'h2c, $random(seed), resp);
    foreach (en_ofs[i]) rchk(en_ofs[i], 32'h0);
    // Corner bits 15 and 0 always set, the rest random, enables all zero.
    foreach (ev_ofs[i])
    begin
      v = $random(seed) | 32'h8001;
      pulse(i, v[15:0]);
      rchk(ev_ofs[i], fit(v));
      rchk(ev_ofs[i], 32'h0);
    end
    wr(8'h0c, 32'h2, resp);
    wr(8'h04, 32'h2000, resp);
    wr(8'h14, 32'd2049, resp);
    rchk(8'h14, 32'h801);
    pulse(2, 16'h0002);
    rchk(8'h08, 32'h0);
    rchk(8'h10, 32'h2);
    pulse(2, 16'h0800);
    repeat (4) @(posedge clk);
    chk("meas_summary", msum, 32'h1);
    rchk(8'h10, 32'h800);
    rchk(8'h08, 32'h2);
    rchk(8'h00, 32'h2000);
    repeat (3) @(posedge clk);
    chk("meas_summary", msum, 32'h0);
    wr(8'h28, 32'd2, resp);
    rchk(8'h28, 32'h2);
    wr(8'h20, 32'h2000, resp);
    pulse(4, 16'hfffd);
    rchk(8'h1c, 32'h0);
    rchk(8'h24, 32'hfffd);
    pulse(4, 16'h0002);
    repeat (4) @(posedge clk);
    chk("oper_summary", osum, 32'h1);
    rchk(8'h24, 32'h2);
    rchk(8'h1c, 32'h2000);
    rchk(8'h30, 32'h3);
    chk("irq masked", irq, 32'h0);
    wr(8'h34, 32'h3, resp);
    repeat (2) @(posedge clk);
    chk("irq", irq, 32'h1);
    wr(8'h30, 32'h1, resp);
    rchk(8'h30, 32'h2);
    wr(8'h30, 32'h2, resp);
    repeat (2) @(posedge clk);
    chk("irq cleared", irq, 32'h0);
    foreach (bad[i])
    begin
      rd(bad[i], d, resp);
      chk("bad rresp", 32'(resp), 32'h2);
      wr(bad[i], 32'hffff, resp);
      chk("bad bresp", 32'(resp), 32'h2);
    end
    // Only the low byte lane is written; the high byte keeps its old value.
    wstrb <= 4'h1;
    wr(8'h04, 32'hffff, resp);
    wstrb <= 4'hf;
    rchk(8'h04, 32'h20ff);
    v = $random(seed);
    cond[2] <= v[15:0];
    repeat (2) @(posedge clk);
    rchk(8'h18, fit(v));
    wr(8'h18, ~v, resp);
    rchk(8'h18, fit(v));
    cond[2] <= 16'h0000;
    give_verdict();
  end

  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
endmodule : status_cascade_tb_top
